// file: rtl/pmcwr_map.svh
// Register map, field positions and reset values of the warning block.
`ifndef PMCWR_MAP_SVH
`define PMCWR_MAP_SVH

// Register indices; the byte address is four times the index.
`define PMCWR_WARN_IDX 8'h01
`define PMCWR_REGU_IDX 8'h02
`define PMCWR_IDX_TO_BYTE 2

// Warning register fields.
`define PMCWR_WARN_FLAG_BIT 7
`define PMCWR_WARN_ACK_BIT 6
`define PMCWR_WARN_IRQ_EN_BIT 5
`define PMCWR_WARN_LVL_LSB 0
`define PMCWR_WARN_LVL_W 2

// Regulator register fields.
`define PMCWR_BG_LP_EN_BIT 4
`define PMCWR_ISO_ACK_BIT 3
`define PMCWR_RUN_REG_BIT 2
`define PMCWR_BG_BUF_EN_BIT 0

// Reset values.
`define PMCWR_WARN_LVL_RST 2'h0
`define PMCWR_RUN_REG_RST 1'h1
`define PMCWR_REG_W 8

// AHB encodings.
`define PMCWR_HRESP_OKAY 1'h0
`define PMCWR_HRESP_ERROR 1'h1
`define PMCWR_HPROT_PRIV_BIT 1

`endif

// file: rtl/pmcwr_pkg.sv
// Types shared by the warning and regulator register block.
package pmcwr_pkg;

    typedef enum logic [5:0] {
        PMCWR_S_IDLE = 6'h01,
        PMCWR_S_WR = 6'h02,
        PMCWR_S_RD = 6'h04,
        PMCWR_S_RDOUT = 6'h08,
        PMCWR_S_ERR1 = 6'h10,
        PMCWR_S_ERR2 = 6'h20
    } pmcwr_state_t;

    typedef logic [7:0] pmcwr_byte_t;

endpackage

// file: rtl/pmcwr_sync.sv
// Two-flop synchroniser for levels arriving from the analog side.
`timescale 1ns/1ps
module pmcwr_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic hclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge hclk or negedge rst_n) begin
        // A per-bit reset value keeps a level that idles high from
        // dipping low until the first real sample has passed through.
        if (!rst_n) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule

// file: rtl/pmcwr_flag.sv
// Sticky warning flag set on a falling supply crossing.
`timescale 1ns/1ps
module pmcwr_flag (
    input wire logic hclk,
    input wire logic rst_n,
    input wire logic below_trip,
    input wire logic clear,
    output logic flag
);
    logic prev_r;
    logic prev_nxt;
    logic flag_r;
    logic flag_nxt;
    logic set_evt;

    // The previous level resets low, so a supply that is already below the
    // trip point right after reset counts as a crossing.
    always_comb begin
        prev_nxt = below_trip;
        set_evt = below_trip & ~prev_r;
        flag_nxt = flag_r;
        if (set_evt) begin
            flag_nxt = 1'b1;
        end else if (clear) begin
            flag_nxt = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;
endmodule

// file: rtl/pmcwr_regs.sv
// Warning and regulator status/control registers behind an AHB-Lite slave.
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "pmcwr_map.svh"
module pmcwr_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic por_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [3:0] hprot,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic supply_below_warn,
    input wire logic regulator_in_run,
    input wire logic isolation_set,
    input wire logic [1:0] detect_level_sel,
    output logic warn_irq,
    output logic [3:0] warn_trip_level,
    output logic isolation_hold,
    output logic bandgap_buffer_en,
    output logic bandgap_lowpower_en
);
    import pmcwr_pkg::*;

    function automatic logic [31:0] idx_to_addr(input logic [7:0] idx);
        idx_to_addr = {22'h0, idx, 2'h0};
    endfunction

    function automatic logic addr_hit(input logic [31:0] a,
                                      input logic [7:0] idx);
        addr_hit = (a == idx_to_addr(idx));
    endfunction

    // Analog levels cross into the bus clock through two flops.
    // The run level resets high so the status bit keeps its reset value
    // until the pin is seen; the warning level resets low for the edge.
    logic [1:0] analog_sync;

    pmcwr_sync #(
        .WIDTH(2),
        .RST_VAL(2'h2)
    ) u_sync (
        .hclk(hclk),
        .rst_n(hresetn),
        .async_in({regulator_in_run, supply_below_warn}),
        .sync_out(analog_sync)
    );

    logic below_s;
    logic run_s;
    assign below_s = analog_sync[0];
    assign run_s = analog_sync[1];

    // Bus front end.
    pmcwr_state_t state_r;
    pmcwr_state_t state_nxt;
    logic [31:0] addr_r;
    logic [31:0] addr_nxt;
    logic hreadyout_r;
    logic hreadyout_nxt;
    logic hresp_r;
    logic hresp_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;

    logic take;
    logic take_wr;
    logic take_rd;
    logic priv;
    logic wr_commit;
    logic hit_warn_w;
    logic hit_regu_w;
    logic hit_warn_r;
    logic hit_regu_r;

    // Register state.
    logic warn_flag;
    logic warn_clear;
    logic warn_irq_en_r;
    logic warn_irq_en_nxt;
    logic [1:0] warn_level_sel_r;
    logic [1:0] warn_level_sel_nxt;
    logic iso_r;
    logic iso_nxt;
    logic run_r;
    logic run_nxt;
    logic bg_buf_r;
    logic bg_buf_nxt;
    logic bg_lp_r;
    logic bg_lp_nxt;
    logic warn_irq_r;
    logic warn_irq_nxt;
    logic [3:0] trip_r;
    logic [3:0] trip_nxt;
    pmcwr_byte_t warn_rd;
    pmcwr_byte_t regu_rd;
    pmcwr_byte_t wbyte;

    assign take = hsel & htrans[1] & hready;
    assign take_wr = take & hwrite;
    assign take_rd = take & ~hwrite;
    assign priv = hprot[`PMCWR_HPROT_PRIV_BIT];
    assign wr_commit = (state_r == PMCWR_S_WR) & hready;
    assign wbyte = hwdata[7:0];

    always_comb begin
        hit_warn_w = 1'b0;
        hit_regu_w = 1'b0;
        if (addr_hit(addr_r, `PMCWR_WARN_IDX)) begin
            hit_warn_w = wr_commit;
        end else if (addr_hit(addr_r, `PMCWR_REGU_IDX)) begin
            hit_regu_w = wr_commit;
        end
    end

    always_comb begin
        hit_warn_r = 1'b0;
        hit_regu_r = 1'b0;
        if (addr_hit(addr_r, `PMCWR_WARN_IDX)) begin
            hit_warn_r = 1'b1;
        end else if (addr_hit(addr_r, `PMCWR_REGU_IDX)) begin
            hit_regu_r = 1'b1;
        end
    end

    // A new address phase is accepted in every state where the slave
    // shows ready, so transfers may follow back to back.
    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        hreadyout_nxt = 1'b1;
        hresp_nxt = `PMCWR_HRESP_OKAY;
        hrdata_nxt = hrdata_r;
        case (state_r)
            PMCWR_S_RD: begin
                // Read data is fetched one cycle late so a write just
                // committed is already visible.
                hrdata_nxt = 32'h0;
                if (hit_warn_r) begin
                    hrdata_nxt = {24'h0, warn_rd};
                end else if (hit_regu_r) begin
                    hrdata_nxt = {24'h0, regu_rd};
                end
                state_nxt = PMCWR_S_RDOUT;
            end
            PMCWR_S_ERR1: begin
                hresp_nxt = `PMCWR_HRESP_ERROR;
                state_nxt = PMCWR_S_ERR2;
            end
            default: begin
                state_nxt = PMCWR_S_IDLE;
                if (take_wr && !priv) begin
                    hreadyout_nxt = 1'b0;
                    hresp_nxt = `PMCWR_HRESP_ERROR;
                    state_nxt = PMCWR_S_ERR1;
                end else if (take_wr) begin
                    addr_nxt = haddr;
                    state_nxt = PMCWR_S_WR;
                end else if (take_rd) begin
                    addr_nxt = haddr;
                    hreadyout_nxt = 1'b0;
                    state_nxt = PMCWR_S_RD;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= PMCWR_S_IDLE;
            addr_r <= 32'h0;
            hreadyout_r <= 1'b1;
            hresp_r <= `PMCWR_HRESP_OKAY;
            hrdata_r <= 32'h0;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            hreadyout_r <= hreadyout_nxt;
            hresp_r <= hresp_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    // Warning flag: hardware set wins over a same-cycle acknowledge.
    assign warn_clear = hit_warn_w & wbyte[`PMCWR_WARN_ACK_BIT];

    pmcwr_flag u_flag (
        .hclk(hclk),
        .rst_n(hresetn),
        .below_trip(below_s),
        .clear(warn_clear),
        .flag(warn_flag)
    );

    // Read views; the warning acknowledge bit and reserved bits return zero; the isolation acknowledge bit reads the hold state.
    always_comb begin
        warn_rd = 8'h0;
        warn_rd[`PMCWR_WARN_FLAG_BIT] = warn_flag;
        warn_rd[`PMCWR_WARN_IRQ_EN_BIT] = warn_irq_en_r;
        warn_rd[1:0] = warn_level_sel_r;
        regu_rd = 8'h0;
        regu_rd[`PMCWR_BG_LP_EN_BIT] = bg_lp_r;
        regu_rd[`PMCWR_ISO_ACK_BIT] = iso_r;
        regu_rd[`PMCWR_RUN_REG_BIT] = run_r;
        regu_rd[`PMCWR_BG_BUF_EN_BIT] = bg_buf_r;
    end

    // Chip-reset domain control bits.
    always_comb begin
        warn_irq_en_nxt = warn_irq_en_r;
        iso_nxt = iso_r;
        bg_buf_nxt = bg_buf_r;
        bg_lp_nxt = bg_lp_r;
        run_nxt = run_s;
        if (hit_warn_w) begin
            warn_irq_en_nxt = wbyte[`PMCWR_WARN_IRQ_EN_BIT];
        end
        if (hit_regu_w) begin
            bg_buf_nxt = wbyte[`PMCWR_BG_BUF_EN_BIT];
            bg_lp_nxt = wbyte[`PMCWR_BG_LP_EN_BIT];
        end
        if (isolation_set) begin
            iso_nxt = 1'b1;
        end else if (hit_regu_w && wbyte[`PMCWR_ISO_ACK_BIT]) begin
            iso_nxt = 1'b0;
        end
        // The interrupt follows the flag level, so a stale power-up flag
        // fires as soon as the enable is set unless software acknowledges it first.
        warn_irq_nxt = warn_flag & warn_irq_en_r;
        trip_nxt = {detect_level_sel, warn_level_sel_r};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            warn_irq_en_r <= 1'b0;
            iso_r <= 1'b0;
            run_r <= `PMCWR_RUN_REG_RST;
            bg_buf_r <= 1'b0;
            bg_lp_r <= 1'b0;
            warn_irq_r <= 1'b0;
            trip_r <= 4'h0;
        end else begin
            warn_irq_en_r <= warn_irq_en_nxt;
            iso_r <= iso_nxt;
            run_r <= run_nxt;
            bg_buf_r <= bg_buf_nxt;
            bg_lp_r <= bg_lp_nxt;
            warn_irq_r <= warn_irq_nxt;
            trip_r <= trip_nxt;
        end
    end

    // The level select survives every reset except power-on.
    always_comb begin
        warn_level_sel_nxt = warn_level_sel_r;
        if (hit_warn_w) begin
            warn_level_sel_nxt = wbyte[1:0];
        end
    end

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            warn_level_sel_r <= `PMCWR_WARN_LVL_RST;
        end else begin
            warn_level_sel_r <= warn_level_sel_nxt;
        end
    end

    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign hrdata = hrdata_r;
    assign warn_irq = warn_irq_r;
    assign warn_trip_level = trip_r;
    assign isolation_hold = iso_r;
    assign bandgap_buffer_en = bg_buf_r;
    assign bandgap_lowpower_en = bg_lp_r;

endmodule

// file: dv/pmcwr_props.sv
// Checker of bus timing and output behaviour of the warning block.
`timescale 1ns/1ps
module pmcwr_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [3:0] hprot,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic isolation_set,
    input wire logic [1:0] detect_level_sel,
    input wire logic warn_irq,
    input wire logic [3:0] warn_trip_level,
    input wire logic isolation_hold,
    input wire logic bandgap_buffer_en
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic tk;
    assign tk = hsel && htrans[1] && hready;
    chk_high_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    chk_trip_lvl: assert property ($past(hresetn) |->
        warn_trip_level[3:2] == $past(detect_level_sel))
        else $error("trip level does not follow detect select");
    chk_user_err: assert property (tk && hwrite && !hprot[1]
        |=> !hreadyout && hresp ##1 hreadyout && hresp)
        else $error("user write without two cycle error");
    chk_ok_write: assert property (tk && hwrite && hprot[1]
        |=> hreadyout && !hresp)
        else $error("privileged write not answered at once");
    chk_read_wait: assert property (tk && !hwrite
        |=> !hreadyout && !hresp ##1 hreadyout)
        else $error("read not answered after one wait state");
    chk_idle_ready: assert property (!tk |=> hreadyout)
        else $error("ready low without a transfer");
    chk_iso_set: assert property (isolation_set
        |-> ##[1:2] isolation_hold)
        else $error("isolation hold not raised");
    chk_irq_rst: assert property ($rose(hresetn) |-> !warn_irq [*2])
        else $error("interrupt request right after reset");
    chk_out_rst: assert property ($rose(hresetn) |->
        !isolation_hold && !bandgap_buffer_en && !hresp)
        else $error("outputs not at reset values");
    cov_user_wr: cover property (tk && hwrite && !hprot[1]);
    cov_read: cover property (tk && !hwrite);
    cov_iso: cover property (isolation_set);
endmodule

// file: dv/tb_top.sv
// Self-checking bench of the warning and regulator register block.
`timescale 1ns/1ps
module tb_top;
    logic hclk, hresetn, por_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, d, r;
    logic [1:0] htrans, detect_level_sel;
    logic [2:0] hsize;
    logic [3:0] hprot, warn_trip_level;
    logic supply_below_warn, regulator_in_run, isolation_set, warn_irq;
    logic isolation_hold, bandgap_buffer_en, bandgap_lowpower_en, e;
    int fails, num_checks, cyc, seed, i;
    assign hready = hreadyout;
    pmcwr_regs uut (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hprot, .hwdata, .hready, .hreadyout, .hresp,
        .hrdata, .supply_below_warn, .regulator_in_run, .isolation_set,
        .detect_level_sel, .warn_irq, .warn_trip_level, .isolation_hold,
        .bandgap_buffer_en, .bandgap_lowpower_en);
    function automatic logic [31:0] wexp(logic f, n, logic [1:0] l);
        return {24'h0, f, 1'h0, n, 3'h0, l};
    endfunction
    function automatic logic [31:0] rexp(logic p, s, u, b);
        return {27'h0, p, s, u, 1'h0, b};
    endfunction
    task automatic chk(input logic [31:0] g, x);
        num_checks++;
        if (g !== x) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, g, x);
        end
    endtask
    // The address phase is held until ready is seen, as a master must.
    task automatic bus(input logic w, input logic [31:0] a, v,
        input logic p);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hprot <= {2'h0, p, 1'h1};
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= v;
        @(posedge hclk);
        while (hreadyout !== 1'h1) @(posedge hclk);
        r = hrdata;
        e = hresp;
    endtask
    task automatic wr(input logic [31:0] a, v);
        bus(1'h1, a, v, 1'h1);
    endtask
    task automatic rd(input logic [31:0] a, x);
        bus(1'h0, a, 32'h0, 1'h1);
        chk(r, x);
    endtask
    task automatic pulse(input logic p);
        hresetn <= 1'h0;
        por_n <= !p;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        por_n <= 1'h1;
        repeat (5) @(posedge hclk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        hclk = 1'h0;
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict;
        end
    end
    initial begin
        {fails, num_checks, cyc} = 0;
        seed = 32'h7dd9;
        {hsel, hwrite, htrans, haddr, hwdata, detect_level_sel} = 0;
        {supply_below_warn, isolation_set} = 0;
        hsize = 3'h2;
        hprot = 4'h3;
        regulator_in_run = 1'h1;
        hresetn = 1'h0;
        por_n = 1'h0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        por_n <= 1'h1;
        @(posedge hclk);
        rd(32'h4, wexp(0, 0, 2'h0));
        rd(32'h8, rexp(0, 0, 1, 0));
        rd(32'h40, 32'h0);
        $display("test 1 done");
        // Ack and reserved bits are written as ones; they must read zero.
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            detect_level_sel <= d[9:8];
            wr(32'h4, {d[31:8], 8'h5c | i[7:0]});
            rd(32'h4, wexp(0, 0, i[1:0]));
            chk({28'h0, warn_trip_level}, {28'h0, d[9:8], i[1:0]});
        end
        $display("test 2 done");
        supply_below_warn <= 1'h1;
        repeat (5) @(posedge hclk);
        rd(32'h4, wexp(1, 0, 2'h3));
        wr(32'h4, 32'h23);
        repeat (2) @(posedge hclk);
        chk({31'h0, warn_irq}, 32'h1);
        wr(32'h4, 32'h63);
        repeat (2) @(posedge hclk);
        chk({31'h0, warn_irq}, 32'h0);
        wr(32'h4, 32'h83);
        rd(32'h4, wexp(0, 0, 2'h3));
        supply_below_warn <= 1'h0;
        repeat (5) @(posedge hclk);
        supply_below_warn <= 1'h1;
        repeat (5) @(posedge hclk);
        rd(32'h4, wexp(1, 0, 2'h3));
        chk({31'h0, warn_irq}, 32'h0);
        $display("test 3 done");
        // Supply stays low across the resets, so the flag must come back.
        wr(32'h4, 32'h23);
        pulse(1'h0);
        rd(32'h4, wexp(1, 0, 2'h3));
        wr(32'h4, 32'h43);
        wr(32'h4, 32'h23);
        repeat (2) @(posedge hclk);
        chk({31'h0, warn_irq}, 32'h0);
        pulse(1'h1);
        rd(32'h4, wexp(1, 0, 2'h0));
        supply_below_warn <= 1'h0;
        $display("test 4 done");
        regulator_in_run <= 1'h0;
        repeat (4) @(posedge hclk);
        rd(32'h8, rexp(0, 0, 0, 0));
        for (i = 0; i < 6; i++) begin
            d = $random(seed);
            wr(32'h8, d);
            rd(32'h8, rexp(d[4], 0, 0, d[0]));
            chk({30'h0, bandgap_lowpower_en, bandgap_buffer_en},
                {30'h0, d[4], d[0]});
        end
        wr(32'h8, 32'h11);
        isolation_set <= 1'h1;
        @(posedge hclk);
        isolation_set <= 1'h0;
        repeat (2) @(posedge hclk);
        rd(32'h8, rexp(1, 1, 0, 1));
        chk({31'h0, isolation_hold}, 32'h1);
        regulator_in_run <= 1'h1;
        wr(32'h8, 32'h18);
        rd(32'h8, rexp(1, 0, 1, 0));
        chk({31'h0, isolation_hold}, 32'h0);
        wr(32'h8, 32'h11);
        pulse(1'h0);
        rd(32'h8, rexp(0, 0, 1, 0));
        $display("test 5 done");
        bus(1'h1, 32'h4, 32'h23, 1'h0);
        chk({31'h0, e}, 32'h1);
        bus(1'h0, 32'h4, 32'h0, 1'h0);
        chk({r[31:1], e}, {wexp(0, 0, 2'h0)});
        $display("test 6 done");
        give_verdict;
    end
endmodule
bind pmcwr_regs pmcwr_props u_props (.hclk, .hresetn, .hsel, .htrans,
    .hwrite, .hprot, .hready, .hreadyout, .hresp, .hrdata,
    .isolation_set, .detect_level_sel, .warn_irq, .warn_trip_level,
    .isolation_hold, .bandgap_buffer_en);
